// ==== rsa_run_stop_arbiter.sv ====
// Run/stop arbiter: merges panel selector, run terminal and remote commands.
// Assumes inputs synchronous-capable levels, rst driven at every power-up,
// and the tool link delivering one-cycle run/stop command pulses.
//
// Operation
// R01: Panel selector alone: RUN position runs the controller, STOP stops it.
// R02: A parameter picks exactly one general-purpose input as the run terminal.
// R03: Selectable run terminal bounded by product size: input 5, 7 or 13 octal.
// R04: Run terminal on forces running; off leaves the selector in charge.
// R05: Without remote commands the state is selector-at-RUN OR terminal asserted.
// R06: Separate start/stop buttons need the user program driving special relays.
// R07: Tool run and stop commands override the selector and run terminal.
// R08: Power-up clears any remote override; local sources decide again.
// R09: Operator should use one local source, selector at STOP with terminal.
// R10: For remote running the operator keeps both local sources at stop.
// R11: After remote stop, remote run or a local stop-then-run resumes running.
// R12: Cassette write-protect off before writing; program written while stopped.
// R13: Never modify the program from two peripheral tools at once.
// R14: Power-up self-diagnosis: run only without faults, else show error.
// R15: Local inputs synchronised; local start detected as edge of combined run.
`timescale 1ns/1ps
module rsa_run_stop_arbiter #(
  parameter logic [1:0] VARIANT = rsa_pkg::VARIANT_LARGE,
  parameter logic [3:0] RUN_TERMINAL = 4'h0,
  parameter logic RUN_TERMINAL_EN = 1'b1
) (
  // Clock and reset (reset is the power-up event)
  input wire logic mclk,
  input wire logic rst,
  // Local sources
  input wire logic selector_run,
  input wire logic [rsa_pkg::NUM_GENERAL_INPUTS-1:0] general_in,
  // Programming tool link commands
  input wire logic remote_run,
  input wire logic remote_stop,
  // Self-diagnosis result
  input wire logic diag_done,
  input wire logic diag_fault,
  // Status
  output logic running,
  output logic run_led,
  output logic err_led,
  output logic terminal_valid
);

  // ==========================================================================
  // Run terminal selection
  function automatic logic [3:0] top_input(input logic [1:0] v);
    unique case (v)
      rsa_pkg::VARIANT_SMALL: top_input = rsa_pkg::SMALL_VARIANT_TOP_INPUT;
      rsa_pkg::VARIANT_MEDIUM: top_input = rsa_pkg::MEDIUM_VARIANT_TOP_INPUT;
      default: top_input = rsa_pkg::LARGE_VARIANT_TOP_INPUT;
    endcase
  endfunction

  // Out-of-range choice disables the terminal rather than picking a wrong pin
  localparam logic TERM_OK = RUN_TERMINAL_EN && (RUN_TERMINAL <= top_input(VARIANT)); // R03

  // ==========================================================================
  // Synchronisers
  // Panel and terminal lines are slow levels; two flops keep them clean
  logic sel_s1, sel_s2, term_s1, term_s2;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      term_s1 <= 1'b0;
      term_s2 <= 1'b0;
    end else begin
      sel_s1 <= selector_run; // R15
      sel_s2 <= sel_s1;
      term_s1 <= general_in[RUN_TERMINAL] & TERM_OK; // R02
      term_s2 <= term_s1;
    end
  end

  // ==========================================================================
  // Combined local run and its rising edge
  logic local_run, local_run_q, local_start;
  assign local_run = sel_s2 | term_s2; // R01 R04 R05
  always_ff @(posedge mclk) begin
    if (rst) local_run_q <= rsa_pkg::RST_LOCAL_RUN;
    else local_run_q <= local_run;
  end
  assign local_start = local_run & ~local_run_q; // R15

  // ==========================================================================
  // Remote override; stop wins when both commands arrive together
  // A local start also drops a remote run, so the panel takes over again
  rsa_pkg::rsa_ovr_t ovr, next_ovr;
  always_comb begin
    next_ovr = ovr;
    if (remote_stop) next_ovr = rsa_pkg::RSA_OVR_STOP; // R07
    else if (remote_run) next_ovr = rsa_pkg::RSA_OVR_RUN; // R07
    else if (local_start) next_ovr = rsa_pkg::RSA_OVR_NONE; // R11
  end
  always_ff @(posedge mclk) begin
    if (rst) ovr <= rsa_pkg::RSA_OVR_NONE; // R08
    else ovr <= next_ovr;
  end

  // ==========================================================================
  // Self-diagnosis gate
  // First result only: a later diag_done cannot clear a latched fault
  logic diag_ok, diag_bad;
  always_ff @(posedge mclk) begin
    if (rst) begin
      diag_ok <= 1'b0;
      diag_bad <= 1'b0;
    end else if (diag_done && !diag_ok && !diag_bad) begin
      diag_ok <= ~diag_fault; // R14
      diag_bad <= diag_fault; // R14
    end
  end

  // ==========================================================================
  // Run state
  logic next_running;
  always_comb begin
    unique case (ovr)
      rsa_pkg::RSA_OVR_RUN: next_running = 1'b1;
      rsa_pkg::RSA_OVR_STOP: next_running = 1'b0;
      default: next_running = local_run;
    endcase
    next_running = next_running & diag_ok; // R14
  end
  always_ff @(posedge mclk) begin
    if (rst) running <= rsa_pkg::RST_RUNNING;
    else running <= next_running;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_led <= 1'b0;
      err_led <= 1'b0;
    end else begin
      // Taken from the next state so it lines up with running
      run_led <= next_running;
      err_led <= diag_bad;
    end
  end

  assign terminal_valid = TERM_OK;

  // ==========================================================================
  // Checks
  AST_NO_RUN_ON_FAULT: assert property (@(posedge mclk) disable iff (rst) // R14
    diag_bad |-> !running) else $error("running with a diagnosis fault");

  AST_LOCAL_OR: assert property (@(posedge mclk) disable iff (rst) // R05
    (ovr == rsa_pkg::RSA_OVR_NONE && diag_ok) |=> running == $past(local_run))
    else $error("local state is not selector OR terminal");

  AST_REMOTE_STOP: assert property (@(posedge mclk) disable iff (rst) // R07
    remote_stop ##1 1'b1 |=> !running) else $error("remote stop ignored");

  AST_REMOTE_RUN: assert property (@(posedge mclk) disable iff (rst) // R07
    (remote_run && !remote_stop && diag_ok) ##1 1'b1 |=> running)
    else $error("remote run ignored");

  AST_RESUME_LOCAL: assert property (@(posedge mclk) disable iff (rst) // R11
    (ovr == rsa_pkg::RSA_OVR_STOP && local_start && !remote_stop && !remote_run)
    |=> ovr == rsa_pkg::RSA_OVR_NONE) else $error("local restart did not resume");

  AST_OVR_CLEARED: assert property (@(posedge mclk) // R08
    $fell(rst) |-> ovr == rsa_pkg::RSA_OVR_NONE) else $error("override survived reset");

  AST_TERMINAL: assert property (@(posedge mclk) disable iff (rst) // R04
    (term_s2 && ovr == rsa_pkg::RSA_OVR_NONE && diag_ok) |=> running)
    else $error("run terminal did not start");

  AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (rst) // R15
    sel_s2 == $past(selector_run, 2) || $past(rst, 2)) else $error("selector sync depth");

  AST_LED: assert property (@(posedge mclk) disable iff (rst) // R14
    run_led == running) else $error("run indicator mismatch");

  // ==========================================================================
  // Reset, override priority, local sources, diagnosis gate, indicators and terminal sync
  AST_RESET_QUIET: assert property (@(posedge mclk) // R08
    rst |=> !running && !run_led && !err_led)
    else $error("outputs active after reset");

  AST_STOP_WINS: assert property (@(posedge mclk) disable iff (rst) // R07
    (remote_stop && remote_run) |=> ovr == rsa_pkg::RSA_OVR_STOP)
    else $error("run beat a simultaneous stop");

  AST_STOPPED_HOLDS: assert property (@(posedge mclk) disable iff (rst) // R07
    ovr == rsa_pkg::RSA_OVR_STOP |=> !running)
    else $error("running under a remote stop");

  AST_FORCED_RUN: assert property (@(posedge mclk) disable iff (rst) // R07
    (ovr == rsa_pkg::RSA_OVR_RUN && diag_ok) |=> running)
    else $error("stopped under a remote run");

  AST_LOCAL_STOP: assert property (@(posedge mclk) disable iff (rst) // R05
    (ovr == rsa_pkg::RSA_OVR_NONE && !local_run) |=> !running)
    else $error("running with both local sources at stop");

  AST_RUN_NEEDS_SOURCE: assert property (@(posedge mclk) disable iff (rst) // R05 R07
    running |-> $past(ovr == rsa_pkg::RSA_OVR_RUN || (ovr == rsa_pkg::RSA_OVR_NONE && local_run)))
    else $error("running without any run source");

  AST_DIAG_GATE: assert property (@(posedge mclk) disable iff (rst) // R14
    !diag_ok |-> !running && !run_led)
    else $error("running before a clean diagnosis");

  AST_ERR_LED: assert property (@(posedge mclk) disable iff (rst) // R14
    err_led |-> !run_led && !running)
    else $error("run and error indicators both lit");

  AST_ERR_STICKY: assert property (@(posedge mclk) disable iff (rst) // R14
    err_led |=> err_led)
    else $error("error indicator dropped without reset");

  AST_TERM_SYNC: assert property (@(posedge mclk) disable iff (rst) // R02
    term_s2 == ($past(general_in[RUN_TERMINAL], 2) & TERM_OK) || $past(rst, 2))
    else $error("run terminal sync depth");

  COV_LOCAL_RUN: cover property (@(posedge mclk) disable iff (rst) local_start ##2 running);
  COV_REMOTE_STOP: cover property (@(posedge mclk) disable iff (rst)
    running ##1 remote_stop ##2 !running);
  COV_RESUME: cover property (@(posedge mclk) disable iff (rst)
    ovr == rsa_pkg::RSA_OVR_STOP ##1 local_start);
  COV_FAULT: cover property (@(posedge mclk) disable iff (rst) diag_bad);
  COV_TERMINAL: cover property (@(posedge mclk) disable iff (rst)
    term_s2 && !sel_s2 ##1 running);

endmodule // rsa_run_stop_arbiter

// ==== rsa_pkg.sv ====
// Package for the run/stop arbiter: input ranges, variant bounds, state codes.
// Assumes a single 200 MHz clock domain; users reference items as rsa_pkg::name.
package rsa_pkg;

  // ==========================================================================
  // General-purpose input range
  localparam int unsigned FIRST_GENERAL_INPUT = 0;
  localparam int unsigned LAST_GENERAL_INPUT = 15;
  localparam int unsigned NUM_GENERAL_INPUTS = 16;

  // ==========================================================================
  // Highest run-terminal input per product size
  localparam logic [3:0] SMALL_VARIANT_TOP_INPUT = 4'h5;
  localparam logic [3:0] MEDIUM_VARIANT_TOP_INPUT = 4'h7;
  localparam logic [3:0] LARGE_VARIANT_TOP_INPUT = 4'hb;

  // Product size codes
  localparam logic [1:0] VARIANT_SMALL = 2'h0;
  localparam logic [1:0] VARIANT_MEDIUM = 2'h1;
  localparam logic [1:0] VARIANT_LARGE = 2'h2;

  // ==========================================================================
  // Values after reset
  localparam logic RST_RUNNING = 1'b0;
  localparam logic RST_LOCAL_RUN = 1'b0;

  // Remote override states
  typedef enum logic [1:0] {
    RSA_OVR_NONE,
    RSA_OVR_RUN,
    RSA_OVR_STOP
  } rsa_ovr_t;

endpackage

// ==== rsa_operator_model.sv ====
// Partner: panel selector, run terminal input and tool link.
// Assumes the arbiter samples on the mclk rising edge.
`timescale 1ns/1ps
module rsa_operator_model (
  // Clock
  input wire logic mclk,
  // Local sources and tool link
  output logic selector_run,
  output logic [rsa_pkg::NUM_GENERAL_INPUTS-1:0] general_in,
  output logic remote_run,
  output logic remote_stop
);
  initial begin
    selector_run = 1'b0;
    general_in = '0;
    remote_run = 1'b0;
    remote_stop = 1'b0;
  end
  // ==========================================================
  // Local levels, moved just after an edge
  task automatic set_local(input logic sel, input logic [15:0] inp);
    @(posedge mclk);
    selector_run <= sel;
    general_in <= inp;
  endtask
  // One tool only, one-cycle command pulse
  task automatic tool(input logic run, input logic stop);
    @(posedge mclk);
    remote_run <= run;
    remote_stop <= stop;
    @(posedge mclk);
    remote_run <= 1'b0;
    remote_stop <= 1'b0;
  endtask
endmodule // rsa_operator_model

// ==== run_stop_arbiter_tb.sv ====
// Bench for the run/stop arbiter, driving it through the operator model.
// Assumes a latency of 3 edges for local inputs and 2 for tool commands.
`timescale 1ns/1ps
module run_stop_arbiter_tb;
  logic mclk, rst, diag_done, diag_fault, selector_run, remote_run, remote_stop;
  logic running, run_led, err_led, terminal_valid;
  logic [15:0] general_in;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  rsa_operator_model OP (.mclk(mclk), .selector_run(selector_run), .general_in(general_in),
    .remote_run(remote_run), .remote_stop(remote_stop));
  rsa_run_stop_arbiter DUT (.mclk(mclk), .rst(rst), .selector_run(selector_run),
    .general_in(general_in), .remote_run(remote_run), .remote_stop(remote_stop),
    .diag_done(diag_done), .diag_fault(diag_fault), .running(running), .run_led(run_led),
    .err_led(err_led), .terminal_valid(terminal_valid));
  // ==========================================================
  // Helpers
  task automatic chk(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic power_up(input logic fault);
    @(posedge mclk);
    rst <= 1'b1;
    diag_done <= 1'b0;
    diag_fault <= fault;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the roughly 140 cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    rst = 1'b1;
    diag_done = 1'b0;
    diag_fault = 1'b0;
    OP.set_local(1'b1, 16'h0000);
    power_up(1'b0);
    wait_n(4);
    chk(running, 1'b0);
    @(posedge mclk);
    diag_done <= 1'b1;
    wait_n(5);
    chk(running, 1'b1);
    chk(run_led, 1'b1);
    chk(err_led, 1'b0);
    chk(terminal_valid, 1'b1);
    for (int i = 0; i < 4; i++) begin
      OP.set_local(i[1], {15'h0000, i[0]});
      wait_n(4);
      chk(running, i[1] | i[0]);
    end
    OP.set_local(1'b0, 16'h0002);
    wait_n(4);
    chk(running, 1'b0);
    OP.tool(1'b1, 1'b0);
    wait_n(3);
    chk(running, 1'b1);
    OP.set_local(1'b1, 16'h0000);
    wait_n(4);
    OP.tool(1'b1, 1'b1);
    wait_n(3);
    chk(running, 1'b0);
    OP.tool(1'b1, 1'b0);
    wait_n(3);
    chk(running, 1'b1);
    OP.tool(1'b0, 1'b1);
    OP.set_local(1'b0, 16'h0000);
    wait_n(4);
    chk(running, 1'b0);
    OP.set_local(1'b1, 16'h0000);
    wait_n(4);
    chk(running, 1'b1);
    OP.set_local(1'b0, 16'h0000);
    OP.tool(1'b1, 1'b0);
    wait_n(3);
    chk(running, 1'b1);
    power_up(1'b0);
    diag_done <= 1'b1;
    wait_n(5);
    chk(running, 1'b0);
    OP.set_local(1'b1, 16'h0000);
    power_up(1'b1);
    diag_done <= 1'b1;
    wait_n(5);
    chk(err_led, 1'b1);
    chk(running, 1'b0);
    end_of_test();
  end
endmodule // run_stop_arbiter_tb
